// ==== shared/amp_protect_pkg.sv ====
`default_nettype none
package amp_protect_pkg;
	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [7:0]  REG_ERROR_STATUS    = 8'h02;
	localparam logic [7:0]  REG_SHUTDOWN_GROUP  = 8'h19;
	localparam logic [7:0]  REG_RETRY_WAIT      = 8'h1c;
	localparam logic [7:0]  REG_OUTPUT_MUX      = 8'h25;
	localparam logic [7:0]  RST_ERROR_STATUS    = 8'h00;
	localparam logic [7:0]  RST_SHUTDOWN_GROUP  = 8'h00;
	localparam logic [7:0]  RST_RETRY_WAIT      = 8'h0a;
	localparam logic [31:0] RST_OUTPUT_MUX      = 32'h0000_0000;
	// Error status bit positions
	localparam int          ERR_BIT_OC          = 0;
	localparam int          ERR_BIT_OT          = 1;
	localparam int          ERR_BIT_UV          = 2;
	// ****************************************
	// Address strap and protection thresholds
	// ****************************************
	localparam logic [5:0]  ADDR_UPPER          = 6'h0d;
	localparam logic [7:0]  OT_TRIP_C           = 8'h96;
	localparam logic [7:0]  OT_HYST_C           = 8'h1e;
	// Supplies are reported in tenths of a volt
	localparam logic [8:0]  STAGE_MIN_DV        = 9'h04c;
	localparam logic [5:0]  LOGIC_MIN_DV        = 6'h1b;
	// Mono pairings expected by the power stage
	localparam logic [31:0] MONO_MUX_A          = 32'h0110_3245;
	localparam logic [7:0]  MONO_GRP_A          = 8'h35;
	localparam logic [31:0] MONO_MUX_B          = 32'h0101_2345;
	localparam logic [7:0]  MONO_GRP_B          = 8'h3a;
	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_PERIOD_NS       = 20;
	localparam int          RETRY_TICK_US       = 1000;
	localparam int          RETRY_TICK_CYCLES   = RETRY_TICK_US * 1000 / CLK_PERIOD_NS;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic uv;
		logic ot;
		logic oc;
	} cause_t;
	typedef struct packed {
		logic       stb;
		logic [7:0] ptr;
		logic [1:0] bidx;
		logic [7:0] data;
	} reg_wr_t;
	// Bytes held by a register, zero when unmapped
	function automatic logic [2:0] reg_bytes(input logic [7:0] ptr);
		case (ptr)
			REG_ERROR_STATUS, REG_SHUTDOWN_GROUP, REG_RETRY_WAIT: reg_bytes = 3'h1;
			REG_OUTPUT_MUX: reg_bytes = 3'h4;
			default: reg_bytes = 3'h0;
		endcase
	endfunction : reg_bytes
endpackage : amp_protect_pkg
`default_nettype wire

// ==== logic/retry_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module retry_timer #(
	parameter int TICK_CYCLES = amp_protect_pkg::RETRY_TICK_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic       load_i,
	input  wire logic [7:0] wait_i,
	output logic            done_o
);
	logic [31:0] div;     // Cycles within one tick
	logic [7:0]  remain;  // Ticks still to run
	logic        busy;    // Interval running
	logic        tick;    // One-cycle tick enable
	assign tick = busy && (div == 32'(TICK_CYCLES - 1));
	// Tick divider, restarted by every load so the first tick is a full one
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div <= 32'h0;
		end else if (load_i || !busy || tick) begin
			div <= 32'h0;
		end else begin
			div <= div + 32'h1;
		end
	end
	// Down-counter; a zero setting still waits one tick
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			remain <= 8'h0;
			busy   <= 1'b0;
			done_o <= 1'b0;
		end else if (load_i) begin
			remain <= (wait_i == 8'h0) ? 8'h1 : wait_i;
			busy   <= 1'b1;
			done_o <= 1'b0;
		end else if (tick) begin
			remain <= remain - 8'h1;
			busy   <= (remain != 8'h1);
			done_o <= (remain == 8'h1);
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule : retry_timer
`default_nettype wire

// ==== logic/thermal_guard.sv ====
`timescale 1ns/1ns
`default_nettype none
module thermal_guard (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] temp_c_i,
	output logic            ot_o
);
	// hysteresis release
	// Trip above the limit, release only after a full hysteresis drop
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ot_o <= 1'b0;
		end else if (temp_c_i > amp_protect_pkg::OT_TRIP_C) begin
			ot_o <= 1'b1;
		end else if (temp_c_i <= amp_protect_pkg::OT_TRIP_C - amp_protect_pkg::OT_HYST_C) begin
			ot_o <= 1'b0;
		end
	end
endmodule : thermal_guard
`default_nettype wire

// ==== logic/amp_protect.sv ====
// Overview of operation
// - Strap pin high gives 0011011, low 0011010
// - Address held after power-up; pin becomes fault
// - Fault pin pulled low at once on error
// - Fault pin released when error status cleared
// - Wait programmed interval before retrying playback
// - Error gone at retry: resume; pin high once status cleared
// - Error present at retry: protect, rewait
// - Fault causes: overcurrent, overtemperature, undervoltage
// - Mono mode: pairs A/B and C/D trip together
// - Select pin floating low means stereo mode
// - Persistent overcurrent holds outputs high impedance until a clean retry
// - Overcurrent recovery once output fault removed
// - Any overcurrent shuts all four half-bridges
// - Above 150 C all outputs high impedance
// - Thermal release after 30 C drop
// - Power-on clears overload; run needs 7.6/2.7 V
// - Undervoltage forces outputs high impedance immediately
// - I2C slave, 100/400 kHz, single/multi-byte
`timescale 1ns/1ns
`default_nettype none
module amp_protect #(
	parameter int RETRY_TICK_CYCLES = amp_protect_pkg::RETRY_TICK_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_b_o,
	input  wire logic        adr_fault_i,
	output logic             adr_fault_o,
	output logic             adr_fault_oe_b_o,
	input  wire logic        parallel_bridge_select_i,
	input  wire logic [3:0]  oc_detect_i,
	input  wire logic [7:0]  temp_c_i,
	input  wire logic [8:0]  power_stage_supply_i,
	input  wire logic [5:0]  logic_supply_i,
	output logic [3:0]       bridge_hiz_o,
	output logic             playback_en_o,
	output logic [6:0]       slave_addr_o,
	output logic [7:0]       shutdown_group_o,
	output logic [31:0]      output_mux_o,
	output logic             mono_cfg_ok_o
);
	// ****************************************
	// Types and signals
	// ****************************************
	typedef enum logic [1:0] {st_boot, st_run, st_protect} prot_state_t;
	typedef enum logic [3:0] {
		i_idle, i_addr, i_aack, i_ptr, i_pack, i_wdata, i_wack, i_rdata, i_rack
	} i2c_state_t;
	prot_state_t              prot_state;      // Protection sequencer
	i2c_state_t               i2c_state;       // Serial slave state
	amp_protect_pkg::cause_t  causes;          // Live fault causes
	amp_protect_pkg::reg_wr_t wr;              // One-cycle register write
	logic [7:0]               error_status;    // Sticky fault record
	logic [7:0]               fault_retry_wait;// Retry interval in ticks
	logic                     addr_sel;        // Strap level
	logic                     boot_done;       // Strap held, pin is fault
	logic                     cause_any;       // Any fault present
	logic                     uv_now;          // Supply below threshold
	logic                     ot_flag;         // Thermal shutdown level
	logic [3:0]               pair_trip;       // Overcurrent after pairing
	logic                     retry_done;      // Interval elapsed pulse
	logic                     retry_load;      // Start or restart interval
	logic                     scl_q;           // Previous SCL
	logic                     sda_q;           // Previous SDA
	logic                     scl_rise;
	logic                     scl_fall;
	logic                     bus_start;
	logic                     bus_stop;
	logic [3:0]               bit_cnt;         // Bits in current byte
	logic [7:0]               shift;           // Received byte
	logic [7:0]               rbyte;           // Byte being sent
	logic                     rw;              // Read transfer
	logic                     nack;            // Master declined more
	logic [7:0]               ptr;             // Register pointer
	logic [1:0]               bidx;            // Byte within register
	logic [9:0]               npos;            // Pointer after this byte
	logic                     drive_low;       // Slave pulls SDA
	// Pointer advance: next byte lane, or next register when full
	function automatic logic [9:0] next_pos(input logic [7:0] p, input logic [1:0] b);
		logic [2:0] nb;
		nb = amp_protect_pkg::reg_bytes(p);
		if ({1'b0, b} + 3'h1 >= nb) begin
			next_pos = {p + 8'h1, 2'h0};
		end else begin
			next_pos = {p, b + 2'h1};
		end
	endfunction : next_pos
	// Read data lane; unmapped addresses read zero
	function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [1:0] b);
		case (p)
			amp_protect_pkg::REG_ERROR_STATUS: rd_byte = error_status;
			amp_protect_pkg::REG_SHUTDOWN_GROUP: rd_byte = shutdown_group_o;
			amp_protect_pkg::REG_RETRY_WAIT: rd_byte = fault_retry_wait;
			amp_protect_pkg::REG_OUTPUT_MUX: rd_byte = output_mux_o[8*(3-b) +: 8];
			default: rd_byte = 8'h00;
		endcase
	endfunction : rd_byte
	// ****************************************
	// Fault causes
	// ****************************************
	// pair grouping
	assign pair_trip = parallel_bridge_select_i ?
		{{2{|oc_detect_i[3:2]}}, {2{|oc_detect_i[1:0]}}} : oc_detect_i;
	assign uv_now = (power_stage_supply_i < amp_protect_pkg::STAGE_MIN_DV) ||
		(logic_supply_i < amp_protect_pkg::LOGIC_MIN_DV);
	assign causes = '{uv: uv_now, ot: ot_flag, oc: |pair_trip};
	assign cause_any = |causes;
	assign boot_done = (prot_state != st_boot);
	thermal_guard u_thermal (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.temp_c_i  (temp_c_i),
		.ot_o      (ot_flag)
	);
	// ****************************************
	// Protection sequencer
	// ****************************************
	// reload on entry and on every failed retry
	assign retry_load = ((prot_state == st_run) && cause_any) ||
		((prot_state == st_protect) && retry_done && cause_any);
	retry_timer #(.TICK_CYCLES(RETRY_TICK_CYCLES)) u_retry (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.load_i    (retry_load),
		.wait_i    (fault_retry_wait),
		.done_o    (retry_done)
	);
	// Boot holds until supplies are good, then run/protect loop
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prot_state <= st_boot;
		end else begin
			case (prot_state)
				st_boot: begin
					if (!uv_now) begin
						prot_state <= st_run;
					end
				end
				st_run: begin
					if (cause_any) begin
						prot_state <= st_protect;
					end
				end
				// resume only when clean at the retry point
				st_protect: begin
					if (retry_done && !cause_any) begin
						prot_state <= st_run;
					end
				end
				default: prot_state <= st_boot;
			endcase
		end
	end
	// all four half-bridges go high impedance together
	assign bridge_hiz_o  = (prot_state != st_run || cause_any) ? 4'hf : 4'h0;
	assign playback_en_o = (prot_state == st_run) && !cause_any;
	// ****************************************
	// Address strap and fault pin
	// ****************************************
	// follow the strap while booting, hold it afterwards
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_sel <= 1'b0;
		end else if (prot_state == st_boot) begin
			addr_sel <= adr_fault_i;
		end
	end
	// strap fills the lowest address bit
	assign slave_addr_o = {amp_protect_pkg::ADDR_UPPER, addr_sel};
	// live cause pulls low before the status bit lands
	assign adr_fault_o      = 1'b0;
	assign adr_fault_oe_b_o = !(boot_done && ((|error_status) || cause_any));
	// ****************************************
	// Registers
	// ****************************************
	// status clears by write, but a new event wins over the clear
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			error_status <= amp_protect_pkg::RST_ERROR_STATUS;
		end else if (wr.stb && wr.ptr == amp_protect_pkg::REG_ERROR_STATUS) begin
			error_status <= wr.data | (boot_done ? {5'h0, causes} : 8'h00);
		end else if (boot_done) begin
			error_status <= error_status | {5'h0, causes};
		end
	end
	// Configuration registers; the mux takes its bytes high lane first
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shutdown_group_o <= amp_protect_pkg::RST_SHUTDOWN_GROUP;
			fault_retry_wait <= amp_protect_pkg::RST_RETRY_WAIT;
			output_mux_o     <= amp_protect_pkg::RST_OUTPUT_MUX;
		end else if (wr.stb) begin
			case (wr.ptr)
				amp_protect_pkg::REG_SHUTDOWN_GROUP: shutdown_group_o <= wr.data;
				amp_protect_pkg::REG_RETRY_WAIT: fault_retry_wait <= wr.data;
				amp_protect_pkg::REG_OUTPUT_MUX: output_mux_o[8*(3-wr.bidx) +: 8] <= wr.data;
				default: ;
			endcase
		end
	end
	assign mono_cfg_ok_o =
		(output_mux_o == amp_protect_pkg::MONO_MUX_A &&
		 shutdown_group_o == amp_protect_pkg::MONO_GRP_A) ||
		(output_mux_o == amp_protect_pkg::MONO_MUX_B &&
		 shutdown_group_o == amp_protect_pkg::MONO_GRP_B);
	// ****************************************
	// Serial control slave
	// ****************************************
	// Edge history; pins are already in this clock domain
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end
	// edge detection is ample at 400 kHz
	assign scl_rise  = scl_i && !scl_q;
	assign scl_fall  = !scl_i && scl_q;
	assign bus_start = scl_i && scl_q && sda_q && !sda_i;
	assign bus_stop  = scl_i && scl_q && !sda_q && sda_i;
	assign npos      = next_pos(ptr, bidx);
	// Byte engine: receive on rise, change data and leave ack on fall
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			i2c_state <= i_idle;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			rbyte     <= 8'h00;
			rw        <= 1'b0;
			nack      <= 1'b0;
			ptr       <= 8'h00;
			bidx      <= 2'h0;
			wr        <= '0;
		end else begin
			wr.stb <= 1'b0;
			if (!boot_done || bus_stop) begin
				i2c_state <= i_idle;
			end else if (bus_start) begin
				i2c_state <= i_addr;
				bit_cnt   <= 4'h0;
			end else begin
				case (i2c_state)
					i_addr, i_ptr, i_wdata: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda_i};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							if (i2c_state == i_addr) begin
								// Foreign address: stay off the bus
								rw        <= shift[0];
								i2c_state <= (shift[7:1] == slave_addr_o) ? i_aack : i_idle;
							end else if (i2c_state == i_ptr) begin
								ptr       <= shift;
								bidx      <= 2'h0;
								i2c_state <= i_pack;
							end else begin
								// Unmapped targets are acked and dropped
								wr        <= '{stb: 1'b1, ptr: ptr, bidx: bidx, data: shift};
								{ptr, bidx} <= npos;
								i2c_state <= i_wack;
							end
						end
					end
					i_aack: begin
						if (scl_fall) begin
							rbyte     <= rd_byte(ptr, bidx);
							i2c_state <= rw ? i_rdata : i_ptr;
						end
					end
					i_pack, i_wack: begin
						if (scl_fall) begin
							i2c_state <= i_wdata;
						end
					end
					i_rdata: begin
						if (scl_rise) begin
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt     <= 4'h0;
							{ptr, bidx} <= npos;
							i2c_state   <= i_rack;
						end else if (scl_fall) begin
							rbyte <= {rbyte[6:0], 1'b0};
						end
					end
					i_rack: begin
						if (scl_rise) begin
							nack <= sda_i;
						end else if (scl_fall) begin
							rbyte     <= rd_byte(ptr, bidx);
							i2c_state <= nack ? i_idle : i_rdata;
						end
					end
					default: i2c_state <= i_idle;
				endcase
			end
		end
	end
	// Open-drain data: only ever pulls low
	assign drive_low  = (i2c_state == i_aack) || (i2c_state == i_pack) ||
		(i2c_state == i_wack) || (i2c_state == i_rdata && !rbyte[7]);
	assign sda_o      = 1'b0;
	assign sda_oe_b_o = !drive_low;
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	addr_strap_a: assert property (boot_done |=> $stable(addr_sel))
		else $error("strap address changed after boot");
	fault_pin_low_a: assert property (boot_done && cause_any |-> !adr_fault_oe_b_o)
		else $error("fault pin not pulled on live fault");
	fault_release_a: assert property (error_status == 8'h00 && !cause_any |-> adr_fault_oe_b_o)
		else $error("fault pin held with status clear");
	retry_resume_a: assert property ((prot_state == st_protect) && retry_done && !cause_any
		|=> prot_state == st_run)
		else $error("no resume at clean retry point");
	retry_again_a: assert property ((prot_state == st_protect) && retry_done && cause_any
		|=> prot_state == st_protect ##1 prot_state == st_protect)
		else $error("left protection with fault present");
	protect_hiz_a: assert property (prot_state == st_protect |-> bridge_hiz_o == 4'hf)
		else $error("bridges driven while protected");
	oc_all_a: assert property (|oc_detect_i |-> bridge_hiz_o == 4'hf && !playback_en_o)
		else $error("overcurrent left a bridge driven");
	ot_trip_a: assert property (temp_c_i > amp_protect_pkg::OT_TRIP_C |=> ot_flag ##0 bridge_hiz_o == 4'hf)
		else $error("no thermal shutdown above trip");
	ot_hold_a: assert property (ot_flag &&
		temp_c_i > amp_protect_pkg::OT_TRIP_C - amp_protect_pkg::OT_HYST_C |=> ot_flag)
		else $error("thermal released before hysteresis");
	boot_wait_a: assert property (prot_state == st_boot && uv_now |=> prot_state == st_boot)
		else $error("left boot with supplies low");
	uv_hiz_a: assert property (uv_now |-> bridge_hiz_o == 4'hf)
		else $error("undervoltage left bridges driven");
	status_sticky_a: assert property (boot_done && causes.oc |=> error_status[amp_protect_pkg::ERR_BIT_OC])
		else $error("overcurrent event lost");
	enter_protect_c: cover property (prot_state == st_run ##1 prot_state == st_protect);
	resume_c: cover property (prot_state == st_protect ##1 prot_state == st_run);
	reg_write_c: cover property (wr.stb && wr.ptr == amp_protect_pkg::REG_OUTPUT_MUX);
	read_ack_c: cover property (i2c_state == i_rack && scl_fall && !nack);
endmodule : amp_protect
`default_nettype wire

// ==== tb/i2c_ctrl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Register bus controller model
// ****************************************
module i2c_ctrl_model (
	input  wire logic clk_sys_i,
	input  wire logic sda_i,
	output var logic  scl_o,
	output var logic  sda_oe_b_o
);
	// Phase length in clocks; the device samples both pins, so phases stay long
	localparam int Q = 5;
	initial begin
		scl_o = 1'b1;
		sda_oe_b_o = 1'b1;
	end
	// Change both lines just after an edge, then hold them one phase
	task automatic step(input logic c, input logic d);
		@(posedge clk_sys_i);
		scl_o <= c;
		sda_oe_b_o <= d;
		repeat (Q - 1) @(posedge clk_sys_i);
	endtask : step
	// one bit
	// Data moves only while the clock is low, sampled at the end of high
	task automatic xfer(input logic d, output logic q);
		step(1'b0, d);
		step(1'b1, d);
		q = sda_i;
		step(1'b0, d);
	endtask : xfer
	task automatic start();
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask : start
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask : stop
	// byte out, acknowledge taken from the device
	task automatic send(input logic [7:0] d, output logic ack);
		logic q;
		for (int i = 7; i >= 0; i--) xfer(d[i], q);
		xfer(1'b1, ack);
	endtask : send
	// byte in, no acknowledge after the last one
	task automatic recv(input logic last, output logic [7:0] d);
		logic q;
		for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
		xfer(last, q);
	endtask : recv
endmodule : i2c_ctrl_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
	// ****************************************
	// Harness
	// ****************************************
	logic        clk = 1'b0, rst_b = 1'b0, strap_hi = 1'b1, pbs = 1'b0, a;
	logic        scl, m_oe_b, d_oe_b, f_oe_b, play, cfg_ok, d_o, f_o;
	logic [3:0]  oc = 4'h0, hiz;
	logic [7:0]  temp = 8'h19, grp;
	logic [8:0]  stage_v = 9'h0f0;
	logic [5:0]  logic_v = 6'h21;
	logic [6:0]  addr7 = 7'h1b, slave;
	logic [31:0] mux, d;
	int          err_total = 0, total_checks = 0, cyc = 0, n;
	logic [7:0]  rptr[5] = '{8'h02, 8'h19, 8'h1c, 8'h25, 8'h03};
	logic [31:0] rexp[5] = '{32'h0, 32'h0, 32'h0a, 32'h0, 32'h0};
	int          rnb[5] = '{1, 1, 1, 4, 1};
	// Open-drain wires; the strap resistor sets the idle fault pin level
	wire logic   sda = m_oe_b & (d_oe_b | d_o);
	wire logic   pin = f_oe_b ? strap_hi : f_o;
	// Short retry tick keeps the waits to a few dozen clocks
	amp_protect #(.RETRY_TICK_CYCLES(4)) i_dut (
		.clk_sys_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(d_o),
		.sda_oe_b_o(d_oe_b), .adr_fault_i(pin), .adr_fault_o(f_o), .adr_fault_oe_b_o(f_oe_b),
		.parallel_bridge_select_i(pbs), .oc_detect_i(oc), .temp_c_i(temp),
		.power_stage_supply_i(stage_v), .logic_supply_i(logic_v), .bridge_hiz_o(hiz),
		.playback_en_o(play), .slave_addr_o(slave), .shutdown_group_o(grp),
		.output_mux_o(mux), .mono_cfg_ok_o(cfg_ok));
	i2c_ctrl_model i_ctrl (.clk_sys_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_b_o(m_oe_b));
	initial begin
		forever #10 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			close_out();
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	task automatic rst_pulse();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask : rst_pulse
	task automatic wr(input logic [7:0] ptr, input logic [31:0] v, input int nb);
		logic k_ack;
		i_ctrl.start();
		i_ctrl.send({addr7, 1'b0}, k_ack);
		check(k_ack, 1'b0);
		i_ctrl.send(ptr, k_ack);
		for (int k = nb - 1; k >= 0; k--) i_ctrl.send(v[8*k +: 8], k_ack);
		i_ctrl.stop();
	endtask : wr
	task automatic rd(input logic [7:0] ptr, input int nb, output logic [31:0] v);
		logic       k_ack;
		logic [7:0] b;
		v = 32'h0;
		i_ctrl.start();
		i_ctrl.send({addr7, 1'b0}, k_ack);
		i_ctrl.send(ptr, k_ack);
		i_ctrl.start();
		i_ctrl.send({addr7, 1'b1}, k_ack);
		for (int k = nb - 1; k >= 0; k--) begin
			i_ctrl.recv(k == 0, b);
			v[8*k +: 8] = b;
		end
		i_ctrl.stop();
	endtask : rd
	// Cycles until playback returns, bounded
	task automatic wait_play();
		n = 0;
		while (play !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_play
	// One fault cause: trip, hold past a retry, clear, then acknowledge
	task automatic trip(input logic [3:0] o, input logic [7:0] t, input logic [7:0] tm,
		input logic [8:0] v, input int b);
		@(posedge clk);
		oc <= o;
		temp <= t;
		stage_v <= v;
		// Thermal flag is registered, so it shows one clock later
		if (t > 8'h96) @(posedge clk);
		#1 check(hiz, 4'hf);
		check(pin, 1'b0);
		check(play, 1'b0);
		@(posedge clk);
		temp <= tm;
		repeat (60) @(posedge clk);
		#1 check(hiz, 4'hf);
		@(posedge clk);
		oc <= 4'h0;
		temp <= 8'h19;
		stage_v <= 9'h0f0;
		wait_play();
		check(play, 1'b1);
		rd(8'h02, 1, d);
		check(d, 32'h1 << b);
		wr(8'h02, 32'h0, 1);
		#1 check(pin, 1'b1);
	endtask : trip
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		rst_pulse();
		check(slave, 7'h1b);
		check(play, 1'b1);
		@(posedge clk);
		strap_hi <= 1'b0;
		repeat (4) @(posedge clk);
		check(slave, 7'h1b);
		strap_hi <= 1'b1;
		$display("test strap done");
		i_ctrl.start();
		i_ctrl.send(8'h50, a);
		i_ctrl.stop();
		check(a, 1'b1);
		wr(8'h03, 32'h55, 1);
		foreach (rptr[i]) begin
			rd(rptr[i], rnb[i], d);
			check(d, rexp[i]);
		end
		$display("test registers done");
		pbs <= 1'b1;
		wr(8'h25, 32'h0110_3245, 4);
		wr(8'h19, 32'h35, 1);
		rd(8'h25, 4, d);
		check(d, 32'h0110_3245);
		check(cfg_ok, 1'b1);
		wr(8'h19, 32'h3a, 1);
		check(cfg_ok, 1'b0);
		wr(8'h25, 32'h0101_2345, 4);
		check(cfg_ok, 1'b1);
		check(mux, 32'h0101_2345);
		check(grp, 8'h3a);
		$display("test mono setup done");
		wr(8'h1c, 32'h05, 1);
		@(posedge clk);
		oc <= 4'b0010;
		#1 check(hiz, 4'hf);
		@(posedge clk);
		oc <= 4'h0;
		wait_play();
		check(n >= 20 && n <= 26, 1'b1);
		wr(8'h02, 32'h0, 1);
		temp <= 8'h96;
		repeat (5) @(posedge clk);
		#1 check(play, 1'b1);
		@(posedge clk);
		pbs <= 1'b0;
		trip(4'b0001, 8'h19, 8'h19, 9'h0f0, 0);
		trip(4'h0, 8'h97, 8'h7d, 9'h0f0, 1);
		trip(4'h0, 8'h19, 8'h19, 9'h04b, 2);
		$display("test protection done");
		@(posedge clk);
		strap_hi <= 1'b0;
		stage_v <= 9'h04b;
		addr7 = 7'h1a;
		rst_pulse();
		check(play, 1'b0);
		@(posedge clk);
		stage_v <= 9'h0f0;
		repeat (4) @(posedge clk);
		check(slave, 7'h1a);
		rd(8'h1c, 1, d);
		check(d, 32'h0a);
		$display("test low strap done");
		close_out();
	end
endmodule : tb
`default_nettype wire
